// File: core/ssfr_core.sv
// Security state decode, exception return check and check fault routing.
`timescale 1ns/10ps
// How it works
// - Top privilege level always reports root state.
// - Lower levels decode two bits into state.
// - Return from top on reserved code illegal.
// - All four privilege levels plus secure hypervisor.
// - No 32-bit above level zero; zero optional.
// - Walk, size, fetch faults raise check exception.
// - Fetch abort checks follow synchronous abort route.
// - Top-level protection fault reports as abort.
// - Route bit one sends protection faults below top level to check.
// - Route bit zero sends protection faults to abort.
// - Check fault beats same-access external abort.
// - Elision may drop second-stage table checks.
// - Check exceptions synchronous, precise, on faulting instruction.
// - Syndrome captures faulting agent level and state.
// - Advertise hardware access flag and dirty update.
// - Random register reads trappable to top level.
// - Advertise sixteen-bit machine identifiers when built.
// - Check exceptions go to top level.
// - Check exceptions carry class code 0x1e.
module ssfr_core
    import ssfr_pkg::*;
#(
    parameter logic LEVEL_ZERO_32BIT = 1'b0,
    parameter logic HAS_VMID16 = 1'b1,
    parameter logic HAS_RANDOM_HW = 1'b0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic reset,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core side requests.
    input wire ssfr_level_t cur_level,
    input wire ssfr_eret_t eret_req,
    input wire ssfr_fault_t fault_req,
    input wire logic random_read,
    // Core side answers.
    output ssfr_sec_t sec_state,
    output ssfr_take_t take,
    output logic eret_illegal,
    output logic eret_done,
    output logic random_trap,
    output logic irq
);

    // ------------------------------------------------------------
    // Security state decode.
    // ------------------------------------------------------------

    // Shared between the live state and the syndrome capture.
    function automatic ssfr_sec_t sec_decode(input ssfr_level_t lvl, input logic ext,
                                             input logic base);
        ssfr_sec_t s;
        if (lvl == LVL_TOP) begin
            s = SEC_ROOT;
        end else if (!ext) begin
            s = base ? SEC_NONSECURE : SEC_SECURE;
        end else begin
            // The reserved code also reads as root so it is never mistaken for realm.
            s = base ? SEC_REALM : SEC_ROOT;
        end
        return s;
    endfunction : sec_decode

    logic [4:0] secure_config_reg;
    logic [0:0] protection_check_ctrl_reg;
    logic [EVT_BITS-1:0] event_status;
    logic [EVT_BITS-1:0] event_mask;
    logic [31:0] top_syndrome_reg;

    wire logic base_nonsecure_bit = secure_config_reg[POS_BASE_NONSECURE_BIT];
    wire logic ext_nonsecure_bit = secure_config_reg[POS_EXT_NONSECURE_BIT];
    wire logic protection_fault_route_bit = secure_config_reg[POS_PROTECTION_FAULT_ROUTE_BIT];
    wire logic ext_abort_sync_route_bit = secure_config_reg[POS_EXT_ABORT_SYNC_ROUTE_BIT];
    wire logic random_trap_bit = secure_config_reg[POS_RANDOM_TRAP_BIT];
    wire logic table_check_elision_bit =
        protection_check_ctrl_reg[POS_TABLE_CHECK_ELISION_BIT];
    wire logic reserved_code = ext_nonsecure_bit & ~base_nonsecure_bit;

    wire ssfr_sec_t next_sec_state = sec_decode(cur_level, ext_nonsecure_bit,
                                                base_nonsecure_bit);

    // ------------------------------------------------------------
    // Exception return check.
    // ------------------------------------------------------------

    // Only a return leaving the top level can consume the reserved code.
    wire logic eret_from_top = eret_req.valid & (cur_level == LVL_TOP) &
                               (eret_req.target != LVL_TOP);
    wire logic next_eret_illegal = eret_from_top & reserved_code;
    wire logic next_eret_done = eret_req.valid & ~next_eret_illegal;

    // ------------------------------------------------------------
    // Random register trap.
    // ------------------------------------------------------------

    // Reads from the top level itself are never trapped.
    wire logic next_random_trap = random_read & random_trap_bit &
                                  (cur_level != LVL_TOP);

    // ------------------------------------------------------------
    // Check fault routing and priority.
    // ------------------------------------------------------------

    // Elision only ever drops the check on a second-stage table descriptor fetch.
    wire logic chk_elided = table_check_elision_bit & fault_req.s2_table_fetch;
    wire logic chk_present = fault_req.valid & (fault_req.kind != CHK_NONE) & ~chk_elided;
    wire logic chk_is_prot = fault_req.kind == CHK_PROT;
    // Walk, size and fetch abort faults use the check class unless the check is elided.
    wire logic prot_to_check = (fault_req.level != LVL_TOP) &
                               protection_fault_route_bit;
    wire logic route_check = chk_present & (~chk_is_prot | prot_to_check);
    wire logic route_prot_abort = chk_present & chk_is_prot & ~prot_to_check;
    // The check fault outranks the plain external abort of the same access.
    wire logic route_ext_abort = fault_req.valid & ~chk_present &
                                 fault_req.access_ext_abort;
    wire logic fetch_abort = route_check & (fault_req.kind == CHK_FETCH_ABORT);

    // Abort target: top stays at top, level two or stage-two walks at two.
    wire ssfr_level_t abort_target =
        (fault_req.level == LVL_TOP) ? LVL_TOP :
        ((fault_req.level == LVL_TWO) | fault_req.s2_table_fetch) ? LVL_TWO : LVL_ONE;

    ssfr_take_t next_take;
    always_comb begin
        next_take = '0;
        next_take.valid = route_check | route_prot_abort | route_ext_abort;
        next_take.is_instr = fault_req.is_instr;
        next_take.tag = fault_req.tag;
        if (route_check) begin
            next_take.reason = RSN_CHECK;
            next_take.target = LVL_TOP;
            next_take.exc_class = CHECK_EXCEPTION_CLASS;
            next_take.serror_vec = fetch_abort & ext_abort_sync_route_bit;
        end else if (route_prot_abort) begin
            next_take.reason = RSN_ABORT_PROT;
            next_take.target = abort_target;
        end else if (route_ext_abort) begin
            next_take.reason = RSN_ABORT_EXT;
            next_take.target = abort_target;
        end
    end

    // ------------------------------------------------------------
    // APB decode.
    // ------------------------------------------------------------

    wire logic apb_access = psel & penable & ~pready;
    wire logic apb_wr = apb_access & pwrite;
    wire logic hit_scr = paddr == OFS_SECURE_CONFIG_REG;
    wire logic hit_pcc = paddr == OFS_PROTECTION_CHECK_CTRL_REG;
    wire logic hit_sts = paddr == OFS_EVENT_STATUS;
    wire logic hit_msk = paddr == OFS_EVENT_MASK;
    wire logic hit_syn = paddr == OFS_TOP_SYNDROME_REG;
    wire logic hit_st = paddr == OFS_CORE_STATE;
    wire logic hit_ft = paddr == OFS_FEATURES;
    wire logic hit_any = hit_scr | hit_pcc | hit_sts | hit_msk | hit_syn | hit_st | hit_ft;
    // Read-only registers ignore writes but do not flag an error.
    wire logic next_pslverr = ~hit_any;

    // Capability word: levels, 32-bit support, update, identifiers, random.
    wire logic [31:0] features = {24'h00_0000, HAS_RANDOM_HW, 1'b1, HAS_VMID16,
                                  1'b1,
                                  LEVEL_ZERO_32BIT, 1'b0,
                                  1'b1, 1'b1};

    wire logic [31:0] next_prdata =
        hit_scr ? {27'h000_0000, secure_config_reg} :
        hit_pcc ? {31'h0000_0000, protection_check_ctrl_reg} :
        hit_sts ? {28'h000_0000, event_status} :
        hit_msk ? {28'h000_0000, event_mask} :
        hit_syn ? top_syndrome_reg :
        hit_st ? {28'h000_0000, cur_level, sec_state} :
        hit_ft ? features : 32'h0000_0000;

    // ------------------------------------------------------------
    // Events and interrupt.
    // ------------------------------------------------------------

    wire logic [EVT_BITS-1:0] evt_set = {route_prot_abort | route_ext_abort, next_random_trap,
                                         next_eret_illegal, route_check};
    wire logic [EVT_BITS-1:0] evt_clr = (apb_wr & hit_sts) ? pwdata[EVT_BITS-1:0] : '0;
    // A new event wins over a write-one-to-clear in the same cycle.
    wire logic [EVT_BITS-1:0] next_event_status = (event_status & ~evt_clr) | evt_set;
    wire logic next_irq = |(next_event_status & event_mask);

    // Syndrome: class, issuing level, agent state, fault kind, tag.
    wire ssfr_sec_t agent_state = sec_decode(fault_req.level, ext_nonsecure_bit,
                                             base_nonsecure_bit);
    wire logic [31:0] next_syndrome = {fault_req.tag, 3'h0, fault_req.kind, agent_state,
                                       fault_req.level, CHECK_EXCEPTION_CLASS};

    // ------------------------------------------------------------
    // Control registers.
    // ------------------------------------------------------------

    // Software writes steer routing; the slave answers one cycle into access.
    always_ff @(posedge clk) begin
        if (reset) begin
            secure_config_reg <= RST_SECURE_CONFIG_REG;
            protection_check_ctrl_reg <= RST_PROTECTION_CHECK_CTRL_REG;
            event_mask <= RST_EVENT_MASK;
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            if (apb_wr & hit_scr) begin
                secure_config_reg <= pwdata[4:0];
            end
            if (apb_wr & hit_pcc) begin
                protection_check_ctrl_reg <= pwdata[0:0];
            end
            if (apb_wr & hit_msk) begin
                event_mask <= pwdata[EVT_BITS-1:0];
            end
            pready <= apb_access;
            pslverr <= apb_access & next_pslverr;
            prdata <= (apb_access & ~pwrite) ? next_prdata : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // Status, syndrome and core side outputs.
    // ------------------------------------------------------------

    // All answers land one edge after the request, so the take is precise.
    always_ff @(posedge clk) begin
        if (reset) begin
            event_status <= '0;
            top_syndrome_reg <= 32'h0000_0000;
            sec_state <= SEC_SECURE;
            take <= '0;
            eret_illegal <= 1'b0;
            eret_done <= 1'b0;
            random_trap <= 1'b0;
            irq <= 1'b0;
        end else begin
            event_status <= next_event_status;
            if (route_check) begin
                top_syndrome_reg <= next_syndrome;
            end
            sec_state <= next_sec_state;
            take <= next_take;
            eret_illegal <= next_eret_illegal;
            eret_done <= next_eret_done;
            random_trap <= next_random_trap;
            irq <= next_irq;
        end
    end

    // ------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------

    a_top_is_root: assert property (
        @(posedge clk) disable iff (reset)
        cur_level == LVL_TOP |=> sec_state == SEC_ROOT)
        else $error("top level did not report root state");

    a_realm_decode: assert property (
        @(posedge clk) disable iff (reset)
        (cur_level != LVL_TOP) && ext_nonsecure_bit && base_nonsecure_bit
        |=> sec_state == SEC_REALM)
        else $error("realm code not decoded as realm");

    a_nonsecure_decode: assert property (
        @(posedge clk) disable iff (reset)
        (cur_level != LVL_TOP) && !ext_nonsecure_bit
        |=> sec_state == ($past(base_nonsecure_bit) ? SEC_NONSECURE : SEC_SECURE))
        else $error("secure or nonsecure decode wrong");

    a_illegal_return: assert property (
        @(posedge clk) disable iff (reset)
        eret_req.valid && cur_level == LVL_TOP && eret_req.target != LVL_TOP
        && reserved_code |=> eret_illegal && !eret_done)
        else $error("reserved code return not flagged illegal");

    a_walk_to_check: assert property (
        @(posedge clk) disable iff (reset)
        fault_req.valid && (fault_req.kind == CHK_WALK || fault_req.kind == CHK_ADDR_SIZE)
        && !chk_elided |=> take.valid && take.reason == RSN_CHECK)
        else $error("walk or size fault not a check exception");

    a_fetch_abort_route: assert property (
        @(posedge clk) disable iff (reset)
        fault_req.valid && fault_req.kind == CHK_FETCH_ABORT && !chk_elided
        |=> take.serror_vec == $past(ext_abort_sync_route_bit))
        else $error("fetch abort ignored synchronous abort routing");

    a_top_prot_abort: assert property (
        @(posedge clk) disable iff (reset)
        fault_req.valid && chk_is_prot && fault_req.level == LVL_TOP && !chk_elided
        |=> take.reason == RSN_ABORT_PROT && take.target == LVL_TOP)
        else $error("top level protection fault not an abort");

    a_prot_route_bit: assert property (
        @(posedge clk) disable iff (reset)
        fault_req.valid && chk_is_prot && fault_req.level != LVL_TOP && !chk_elided
        |=> take.reason == ($past(protection_fault_route_bit) ? RSN_CHECK : RSN_ABORT_PROT))
        else $error("protection fault routing bit not obeyed");

    a_check_priority: assert property (
        @(posedge clk) disable iff (reset)
        fault_req.valid && fault_req.kind != CHK_NONE && fault_req.access_ext_abort
        && !table_check_elision_bit |=> take.reason != RSN_ABORT_EXT)
        else $error("external abort beat a check fault");

    a_elided_check: assert property (
        @(posedge clk) disable iff (reset)
        fault_req.valid && table_check_elision_bit && fault_req.s2_table_fetch
        |=> take.reason != RSN_CHECK)
        else $error("elided table check still raised");

    a_check_class: assert property (
        @(posedge clk) disable iff (reset)
        take.valid && take.reason == RSN_CHECK
        |-> take.target == LVL_TOP && take.exc_class == CHECK_EXCEPTION_CLASS
            && $past(fault_req.tag) == take.tag)
        else $error("check exception class, target or tag wrong");

    a_random_trap: assert property (
        @(posedge clk) disable iff (reset)
        random_read && random_trap_bit && cur_level != LVL_TOP
        |=> random_trap && event_status[POS_EVT_RANDOM_TRAP])
        else $error("random register read not trapped");

endmodule : ssfr_core

// File: core/ssfr_pkg.sv
// Package for the security state and check fault routing block.
package ssfr_pkg;

    // ------------------------------------------------------------
    // Register byte offsets on the APB slave.
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_SECURE_CONFIG_REG = 8'h00;
    localparam logic [7:0] OFS_PROTECTION_CHECK_CTRL_REG = 8'h04;
    localparam logic [7:0] OFS_EVENT_STATUS = 8'h08;
    localparam logic [7:0] OFS_EVENT_MASK = 8'h0c;
    localparam logic [7:0] OFS_TOP_SYNDROME_REG = 8'h10;
    localparam logic [7:0] OFS_CORE_STATE = 8'h14;
    localparam logic [7:0] OFS_FEATURES = 8'h18;

    // ------------------------------------------------------------
    // Field positions.
    // ------------------------------------------------------------
    localparam int POS_BASE_NONSECURE_BIT = 0;
    localparam int POS_EXT_NONSECURE_BIT = 1;
    localparam int POS_PROTECTION_FAULT_ROUTE_BIT = 2;
    localparam int POS_EXT_ABORT_SYNC_ROUTE_BIT = 3;
    localparam int POS_RANDOM_TRAP_BIT = 4;
    localparam int POS_TABLE_CHECK_ELISION_BIT = 0;
    localparam int POS_EVT_CHECK = 0;
    localparam int POS_EVT_ILLEGAL_RETURN = 1;
    localparam int POS_EVT_RANDOM_TRAP = 2;
    localparam int POS_EVT_ABORT = 3;
    localparam int EVT_BITS = 4;

    // ------------------------------------------------------------
    // Reset values and fixed codes.
    // ------------------------------------------------------------
    localparam logic [4:0] RST_SECURE_CONFIG_REG = 5'h00;
    localparam logic [0:0] RST_PROTECTION_CHECK_CTRL_REG = 1'h0;
    localparam logic [3:0] RST_EVENT_MASK = 4'h0;
    localparam logic [5:0] CHECK_EXCEPTION_CLASS = 6'h1e;

    // ------------------------------------------------------------
    // Types.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LVL_ZERO, LVL_ONE, LVL_TWO, LVL_TOP
    } ssfr_level_t;

    typedef enum logic [1:0] {
        SEC_SECURE, SEC_NONSECURE, SEC_ROOT, SEC_REALM
    } ssfr_sec_t;

    typedef enum logic [2:0] {
        CHK_NONE, CHK_PROT, CHK_WALK, CHK_ADDR_SIZE, CHK_FETCH_ABORT
    } ssfr_chk_t;

    typedef enum logic [1:0] {
        RSN_NONE, RSN_CHECK, RSN_ABORT_PROT, RSN_ABORT_EXT
    } ssfr_reason_t;

    typedef struct packed {
        logic valid;
        ssfr_level_t target;
    } ssfr_eret_t;

    typedef struct packed {
        logic valid;
        ssfr_chk_t kind;
        ssfr_level_t level;
        logic s2_table_fetch;
        logic access_ext_abort;
        logic is_instr;
        logic [15:0] tag;
    } ssfr_fault_t;

    typedef struct packed {
        logic valid;
        ssfr_reason_t reason;
        logic is_instr;
        ssfr_level_t target;
        logic [5:0] exc_class;
        logic serror_vec;
        logic [15:0] tag;
    } ssfr_take_t;

endpackage : ssfr_pkg

// File: bench/tb_top.sv
// Self-checking bench for the security state and fault routing core.
`timescale 1ns/10ps
module tb_top;
    import ssfr_pkg::*;
    // ------------------------------------------------------------
    // Signals and design under test.
    // ------------------------------------------------------------
    localparam logic Z32 = 1'b1;
    localparam logic V16 = 1'b1;
    localparam logic RHW = 1'b0;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    ssfr_level_t cur_level = LVL_ZERO;
    ssfr_eret_t eret_req = '0;
    ssfr_fault_t fault_req = '0;
    logic random_read = 1'b0;
    ssfr_sec_t sec_state;
    ssfr_take_t take;
    logic eret_illegal;
    logic eret_done;
    logic random_trap;
    logic irq;
    int n_errors = 0;
    int comparisons = 0;
    logic [31:0] rd;
    logic err;
    logic [3:0] m_status = 4'h0;
    logic [31:0] m_syn = 32'h0000_0000;

    ssfr_core #(.LEVEL_ZERO_32BIT(Z32), .HAS_VMID16(V16), .HAS_RANDOM_HW(RHW)) ssfr_core_i (
        .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cur_level(cur_level), .eret_req(eret_req), .fault_req(fault_req),
        .random_read(random_read), .sec_state(sec_state), .take(take),
        .eret_illegal(eret_illegal), .eret_done(eret_done), .random_trap(random_trap),
        .irq(irq));

    // Free running 125 MHz clock.
    always #4 clk = ~clk;

    // ------------------------------------------------------------
    // Shared tasks and the reference model.
    // ------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
        comparisons++;
        if (got !== ex) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask : chk

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict

    // One APB transfer; the wait is bounded only by the watchdog.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rreg(input string nm, input logic [7:0] a, input logic [31:0] ex,
                        input logic [31:0] msk);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, ex, rd & msk);
        chk("slave_error", 32'h0000_0000, {31'h0, err});
    endtask : rreg

    // Lets the next edge land, then looks after it has settled.
    task automatic settle();
        @(posedge clk);
        #1;
    endtask : settle

    // Expected security state: top level or the reserved code read as root.
    function automatic logic [1:0] xsec(input int lv, input logic [1:0] c);
        return (lv == 3 || c == 2'h2) ? 2'h2 : c;
    endfunction : xsec

    // Expected exception for one faulting access.
    function automatic ssfr_take_t fmodel(ssfr_fault_t f, logic [4:0] cfg, logic el);
        ssfr_take_t e;
        logic ok;
        e = '0;
        ok = f.kind != CHK_NONE && !(el && f.s2_table_fetch);
        e.is_instr = f.is_instr;
        e.tag = f.tag;
        e.target = (f.level == LVL_TOP) ? LVL_TOP :
            (f.level == LVL_TWO || f.s2_table_fetch) ? LVL_TWO : LVL_ONE;
        if (ok && (f.kind != CHK_PROT || (f.level != LVL_TOP && cfg[2]))) begin
            e.reason = RSN_CHECK;
            e.target = LVL_TOP;
            e.exc_class = 6'h1e;
            e.serror_vec = f.kind == CHK_FETCH_ABORT && cfg[3];
        end else if (ok) begin
            e.reason = RSN_ABORT_PROT;
        end else if (f.access_ext_abort) begin
            e.reason = RSN_ABORT_EXT;
        end
        e.valid = e.reason != RSN_NONE;
        return e;
    endfunction : fmodel

    // Watchdog, about forty-five times the expected length of the run.
    initial begin
        #200000;
        n_errors++;
        give_verdict();
    end

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        ssfr_fault_t f;
        ssfr_take_t e;
        logic [4:0] cfg;
        logic el;
        logic ill;
        logic [1:0] xs;
        void'($urandom(20));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        settle();
        chk("reset_outputs", 32'h0000_0000, {take, irq, sec_state});
        for (int a = 0; a < 5; a++) rreg("reset_value", 8'(a * 4), 32'h0, 32'hffff_ffff);
        // Fixed capabilities, a refused write to them and an unmapped address.
        apb(1'b1, OFS_FEATURES, 32'h0000_0000);
        rreg("features", OFS_FEATURES, {24'h0, RHW, 1'b1, V16, 1'b1, Z32, 3'h3}, 32'hffff_ffff);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped_error", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
        // Security state for every level and code, and returns from the top level.
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, OFS_SECURE_CONFIG_REG, 32'(c));
            for (int lv = 0; lv < 4; lv++) begin
                @(posedge clk);
                cur_level <= ssfr_level_t'(lv);
                settle();
                xs = xsec(lv, 2'(c));
                chk("sec_state", {30'h0, xs}, {30'h0, sec_state});
                rreg("core_state", OFS_CORE_STATE, {28'h0, 2'(lv), xs}, 32'h0000_000f);
            end
            for (int t = 0; t < 4; t++) begin
                @(posedge clk);
                eret_req <= '{valid: 1'b1, target: ssfr_level_t'(t)};
                @(posedge clk);
                eret_req <= '0;
                #1;
                ill = t != 3 && c == 2;
                chk("eret_illegal", {31'h0, ill}, {31'h0, eret_illegal});
                chk("eret_done", {31'h0, !ill}, {31'h0, eret_done});
                m_status[1] = m_status[1] | ill;
            end
        end
        // Random register reads trap only below the top level when enabled.
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, OFS_SECURE_CONFIG_REG, 32'(k / 4) << 4);
            @(posedge clk);
            cur_level <= ssfr_level_t'(k % 4);
            @(posedge clk);
            random_read <= 1'b1;
            @(posedge clk);
            random_read <= 1'b0;
            #1;
            ill = k >= 4 && k % 4 != 3;
            chk("random_trap", {31'h0, ill}, {31'h0, random_trap});
            m_status[2] = m_status[2] | ill;
        end
        // Sticky status, masking and clearing by writing ones.
        rreg("status", OFS_EVENT_STATUS, {28'h0, m_status}, 32'hffff_ffff);
        chk("irq_masked", 32'h0, {31'h0, irq});
        apb(1'b1, OFS_EVENT_MASK, 32'h0000_000f);
        settle();
        chk("irq_raised", 32'h1, {31'h0, irq});
        apb(1'b1, OFS_EVENT_STATUS, 32'h0000_000f);
        m_status = 4'h0;
        settle();
        chk("irq_cleared", 32'h0, {31'h0, irq});
        // Random faults under changing routing, elision and abort settings.
        for (int i = 0; i < 96; i++) begin
            if (i % 8 == 0) begin
                cfg = 5'($urandom_range(0, 15));
                el = 1'($urandom_range(0, 1));
                apb(1'b1, OFS_SECURE_CONFIG_REG, {27'h0, cfg});
                apb(1'b1, OFS_PROTECTION_CHECK_CTRL_REG, {31'h0, el});
            end
            f = '0;
            f.valid = 1'b1;
            f.kind = ssfr_chk_t'($urandom_range(0, 4));
            f.level = ssfr_level_t'($urandom_range(0, 3));
            f.s2_table_fetch = 1'($urandom);
            f.access_ext_abort = 1'($urandom);
            f.is_instr = 1'($urandom);
            f.tag = 16'($urandom);
            e = fmodel(f, cfg, el);
            @(posedge clk);
            fault_req <= f;
            @(posedge clk);
            fault_req <= '0;
            #1;
            chk("take_valid", {31'h0, e.valid}, {31'h0, take.valid});
            if (e.valid) chk("take", 32'(e), 32'(take));
            if (e.reason == RSN_CHECK) begin
                m_status[0] = 1'b1;
                m_syn = {f.tag, 3'h0, f.kind, xsec(f.level, cfg[1:0]), f.level, 6'h1e};
            end else if (e.valid) begin
                m_status[3] = 1'b1;
            end
        end
        rreg("syndrome", OFS_TOP_SYNDROME_REG, m_syn, 32'hffff_1fff);
        rreg("status", OFS_EVENT_STATUS, {28'h0, m_status}, 32'hffff_ffff);
        chk("irq_level", {31'h0, |m_status}, {31'h0, irq});
        give_verdict();
    end
endmodule : tb_top
